// ===== rtl/rspi_port.sv
// Command port core: command decoding, clear-to-send, sequencer, receive buffer
module rspi_port (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic chip_select_n,
   input wire logic spi_sdi,
   output logic sdo_out,
   output logic sdo_oe_n,
   input wire logic shutdown,
   input rspi_pkg::rspi_stream_t rx_in,
   output logic rx_in_ready,
   input wire logic rx_serial_bit,
   input wire logic gpio_rx_mode,
   input wire logic [3:0][1:0] quick_status_source_select,
   input wire logic tx_done,
   output logic [7:0] pa_level,
   output logic tx_active,
   output logic rx_active,
   output logic gpio_rx
);
   ////////////////////////////////////////////////////////////////////////////////
   // State of the core domain
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_prev;
      logic cs_old;
      logic tg_s1;
      logic tg_s2;
      logic tg_prev;
      logic sdn_s1;
      logic sdn_s2;
      logic [6:0] byte_n;
      logic [7:0] cmd;
      logic [7:0] run_cmd;
      logic [7:0] params;
      logic [6:0] pops;
      logic [8:0] timer;
      logic busy;
      logic plain_cmd;
      rspi_pkg::rspi_seq_t seq;
      logic [7:0] pa;
      logic want_rx;
      logic gpio;
      rspi_pkg::rspi_shadow_t sh;
   } rspi_core_st_t;

   rspi_core_st_t st_reg;
   rspi_core_st_t st_next;
   rspi_pkg::rspi_byte_evt_t byte_evt;
   logic [3:0][7:0] qs_val;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic fifo_out_ready;
   logic frame_on;
   logic frame_end;
   logic byte_seen;
   logic shut;
   logic transit;
   logic is_qs;
   logic is_passive;
   logic [5:0] wr_idx;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial link end on its own clock
   rspi_link u_link (
      .spi_sclk(spi_sclk),
      .rst(rst),
      .chip_select_n(chip_select_n),
      .spi_sdi(spi_sdi),
      .shadow(st_reg.sh),
      .byte_evt(byte_evt),
      .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Receive FIFO between demodulator and receive buffer
   rspi_fifo #(
      .WIDTH(rspi_pkg::DATA_W),
      .DEPTH(rspi_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(fifo_in_valid),
      .in_data(rx_in.data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_out_ready)
   );

   // Demodulator only feeds the FIFO while receiving
   assign fifo_in_valid = rx_in.valid & rx_active;
   assign rx_in_ready = fifo_in_ready & rx_active;

   // Buffer fills only between frames, so the link sees stable data; the cycle
   // that commits a frame's reads is skipped so head and count stay consistent
   assign fifo_out_ready = ~frame_on & ~frame_end & ~shut &
                           (st_reg.sh.rx_count < rspi_pkg::RX_BUF_DEPTH);
   assign wr_idx = st_reg.sh.rx_head + st_reg.sh.rx_count[5:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Frame and event decode from synchronised link signals
   assign frame_on = ~st_reg.cs_s2;
   // Frame end one stage after select rises, never before the last byte event
   assign frame_end = st_reg.cs_prev & ~st_reg.cs_old;
   assign byte_seen = st_reg.tg_s2 ^ st_reg.tg_prev;
   assign shut = st_reg.sdn_s2;
   assign transit = (st_reg.seq == rspi_pkg::SEQ_TX_RAMP) ||
                    (st_reg.seq == rspi_pkg::SEQ_TX_FALL);
   assign is_qs = (byte_evt.data == rspi_pkg::CMD_QS_A) ||
                  (byte_evt.data == rspi_pkg::CMD_QS_B) ||
                  (byte_evt.data == rspi_pkg::CMD_QS_C) ||
                  (byte_evt.data == rspi_pkg::CMD_QS_D);
   // Reads leave clear-to-send untouched
   assign is_passive = is_qs ||
                       (byte_evt.data == rspi_pkg::CMD_READ_REPLY) ||
                       (byte_evt.data == rspi_pkg::CMD_READ_RX);

   // Sequencer outputs
   assign tx_active = (st_reg.seq == rspi_pkg::SEQ_TX_RAMP) ||
                      (st_reg.seq == rspi_pkg::SEQ_TX_ON) ||
                      (st_reg.seq == rspi_pkg::SEQ_TX_FALL);
   assign rx_active = st_reg.seq == rspi_pkg::SEQ_RX_ON;
   assign pa_level = st_reg.pa;
   assign gpio_rx = st_reg.gpio;

   ////////////////////////////////////////////////////////////////////////////////
   // Quick status source per register
   for (genvar i = 0; i < 4; i++) begin : g_qs
      always_comb begin
         unique case (quick_status_source_select[i])
            rspi_pkg::QS_SRC_STATE: qs_val[i] = {3'h0, st_reg.seq};
            rspi_pkg::QS_SRC_RX_COUNT: qs_val[i] = {1'b0, st_reg.sh.rx_count};
            rspi_pkg::QS_SRC_PA: qs_val[i] = st_reg.pa;
            rspi_pkg::QS_SRC_OFF: qs_val[i] = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state of the core
   always_comb begin
      st_next = st_reg;

      // Two-stage synchronisers for select, byte toggle and shutdown
      st_next.cs_s1 = chip_select_n;
      st_next.cs_s2 = st_reg.cs_s1;
      st_next.cs_prev = st_reg.cs_s2;
      st_next.cs_old = st_reg.cs_prev;
      st_next.tg_s1 = byte_evt.tog;
      st_next.tg_s2 = st_reg.tg_s1;
      st_next.tg_prev = st_reg.tg_s2;
      st_next.sdn_s1 = shutdown;
      st_next.sdn_s2 = st_reg.sdn_s1;

      // Bytes of the current frame; counting follows select one stage late,
      // so the last byte of a frame is always taken before the frame ends
      if (st_reg.cs_prev) begin
         st_next.byte_n = 7'h00;
      end else if (byte_seen) begin
         if (st_reg.byte_n != 7'h7F) begin
            st_next.byte_n = st_reg.byte_n + 7'h01;
         end
         if (st_reg.byte_n == 7'h00) begin
            st_next.cmd = byte_evt.data;
            st_next.plain_cmd = ~is_passive;
            // Reads must not overwrite the command whose reply is pending
            if (!is_passive) begin
               st_next.run_cmd = byte_evt.data;
               st_next.params = 8'h00;
               st_next.busy = 1'b1;
            end
         end else if (st_reg.cmd == rspi_pkg::CMD_READ_RX) begin
            if (st_reg.pops < st_reg.sh.rx_count) begin
               st_next.pops = st_reg.pops + 7'h01;
            end
         end else if (st_reg.plain_cmd && st_reg.params != 8'hFF) begin
            st_next.params = st_reg.params + 8'h01;
         end
      end

      // Internal controller works for a fixed time per command
      if (st_reg.timer != 9'h000) begin
         st_next.timer = st_reg.timer - 9'h001;
      end else if (st_reg.busy && !st_reg.plain_cmd && !transit) begin
         st_next.busy = 1'b0;
         st_next.sh.reply[0] = st_reg.run_cmd;
         st_next.sh.reply[1] = st_reg.params;
         st_next.sh.reply[2] = {3'h0, st_reg.seq};
         st_next.sh.reply[3] = {1'b0, st_reg.sh.rx_count};
      end

      // Power amplifier ramps and state sequencing
      unique case (st_reg.seq)
         rspi_pkg::SEQ_IDLE: begin
            st_next.pa = 8'h00;
         end
         rspi_pkg::SEQ_TX_RAMP: begin
            if (st_reg.pa == rspi_pkg::PA_MAX) begin
               st_next.seq = rspi_pkg::SEQ_TX_ON;
            end else begin
               st_next.pa = st_reg.pa + 8'h01;
            end
         end
         rspi_pkg::SEQ_TX_ON: begin
            if (tx_done) begin
               st_next.seq = rspi_pkg::SEQ_TX_FALL;
            end
         end
         rspi_pkg::SEQ_TX_FALL: begin
            if (st_reg.pa == 8'h00) begin
               st_next.seq = st_reg.want_rx ? rspi_pkg::SEQ_RX_ON : rspi_pkg::SEQ_IDLE;
               st_next.want_rx = 1'b0;
            end else begin
               st_next.pa = st_reg.pa - 8'h01;
            end
         end
         rspi_pkg::SEQ_RX_ON: begin
            st_next.pa = 8'h00;
         end
         default: begin
            st_next.seq = rspi_pkg::SEQ_IDLE;
         end
      endcase

      // End of frame: commit buffer reads and launch the command
      if (frame_end) begin
         st_next.sh.rx_head = st_reg.sh.rx_head + st_reg.pops[5:0];
         st_next.sh.rx_count = st_reg.sh.rx_count - st_reg.pops;
         st_next.pops = 7'h00;
         if (st_reg.plain_cmd) begin
            st_next.timer = rspi_pkg::CTS_LOAD;
            st_next.plain_cmd = 1'b0;
            if (st_reg.cmd == rspi_pkg::CMD_START_TX) begin
               if (st_reg.seq == rspi_pkg::SEQ_IDLE || st_reg.seq == rspi_pkg::SEQ_RX_ON) begin
                  st_next.seq = rspi_pkg::SEQ_TX_RAMP;
               end
            end else if (st_reg.cmd == rspi_pkg::CMD_START_RX) begin
               if (st_reg.seq == rspi_pkg::SEQ_IDLE) begin
                  st_next.seq = rspi_pkg::SEQ_RX_ON;
               end else if (st_reg.seq == rspi_pkg::SEQ_TX_RAMP ||
                            st_reg.seq == rspi_pkg::SEQ_TX_ON) begin
                  st_next.seq = rspi_pkg::SEQ_TX_FALL;
                  st_next.want_rx = 1'b1;
               end else if (st_reg.seq == rspi_pkg::SEQ_TX_FALL) begin
                  st_next.want_rx = 1'b1;
               end
            end
         end
      end

      // Move FIFO output into the receive buffer
      if (fifo_out_valid && fifo_out_ready) begin
         st_next.sh.rx_buf[wr_idx] = fifo_out_data;
         st_next.sh.rx_count = st_reg.sh.rx_count + 7'h01;
      end

      // Receive data also mirrored on the general-purpose pin
      st_next.gpio = gpio_rx_mode & rx_active & rx_serial_bit;

      // Quick status and clear-to-send shadows refreshed only while no frame is seen
      if (!frame_on) begin
         st_next.sh.qs = qs_val;
         st_next.sh.cts = ~st_reg.busy & ~transit;
      end
      st_next.sh.link_en = ~shut;

      // Shutdown loses every register, keeps only the synchronisers
      if (shut) begin
         st_next = '0;
         st_next.seq = rspi_pkg::SEQ_IDLE;
         st_next.cs_s1 = chip_select_n;
         st_next.cs_s2 = st_reg.cs_s1;
         st_next.cs_prev = st_reg.cs_s2;
         st_next.cs_old = st_reg.cs_prev;
         st_next.tg_s1 = byte_evt.tog;
         st_next.tg_s2 = st_reg.tg_s1;
         st_next.tg_prev = st_reg.tg_s2;
         st_next.sdn_s1 = shutdown;
         st_next.sdn_s2 = st_reg.sdn_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Core state register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.seq <= rspi_pkg::SEQ_IDLE;
         // Select chain starts at the idle level, so no false frame follows reset
         st_reg.cs_s1 <= 1'b1;
         st_reg.cs_s2 <= 1'b1;
         st_reg.cs_prev <= 1'b1;
         st_reg.cs_old <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule // rspi_port

// ===== rtl/rspi_pkg.sv
// Shared constants and types of the radio serial command port
package rspi_pkg;
   // Timing
   localparam int CORE_PERIOD_NS = 50;
   localparam int CTS_TIME_NS = 20000;
   localparam int CTS_CYCLES = CTS_TIME_NS / CORE_PERIOD_NS;
   localparam logic [8:0] CTS_LOAD = 9'(CTS_CYCLES);
   localparam int SCLK_MAX_HZ = 10000000;
   ////////////////////////////////////////////////////////////////////////////////
   // Command codes
   localparam logic [7:0] CMD_QS_A = 8'h51;
   localparam logic [7:0] CMD_QS_B = 8'h53;
   localparam logic [7:0] CMD_QS_C = 8'h55;
   localparam logic [7:0] CMD_QS_D = 8'h57;
   localparam logic [7:0] CMD_READ_REPLY = 8'h44;
   localparam logic [7:0] CMD_READ_RX = 8'h77;
   localparam logic [7:0] CMD_START_TX = 8'h31;
   localparam logic [7:0] CMD_START_RX = 8'h32;
   localparam logic [7:0] CTS_READY = 8'hFF;
   localparam logic [7:0] CTS_BUSY = 8'h00;
   ////////////////////////////////////////////////////////////////////////////////
   // Sizes and levels
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 32;
   localparam logic [6:0] RX_BUF_DEPTH = 7'h40;
   localparam logic [7:0] PA_MAX = 8'hFF;
   // Quick status sources
   localparam logic [1:0] QS_SRC_OFF = 2'h0;
   localparam logic [1:0] QS_SRC_STATE = 2'h1;
   localparam logic [1:0] QS_SRC_RX_COUNT = 2'h2;
   localparam logic [1:0] QS_SRC_PA = 2'h3;
   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [4:0] {
      SEQ_IDLE = 5'h01,
      SEQ_TX_RAMP = 5'h02,
      SEQ_TX_ON = 5'h04,
      SEQ_TX_FALL = 5'h08,
      SEQ_RX_ON = 5'h10
   } rspi_seq_t;
   // Values held stable for the link while a frame runs
   typedef struct packed {
      logic [63:0][7:0] rx_buf;
      logic [5:0] rx_head;
      logic [6:0] rx_count;
      logic [3:0][7:0] qs;
      logic [3:0][7:0] reply;
      logic cts;
      logic link_en;
   } rspi_shadow_t;
   // Command byte of the frame from the link, with an event toggle per completed byte
   typedef struct packed {
      logic [7:0] data;
      logic tog;
   } rspi_byte_evt_t;
   typedef struct packed {
      logic [7:0] data;
      logic valid;
   } rspi_stream_t;
endpackage

// ===== rtl/rspi_fifo.sv
// Receive data FIFO with valid and ready on both sides
module rspi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } rspi_fifo_st_t;
   rspi_fifo_st_t st_reg;
   rspi_fifo_st_t st_next;
   // Full when pointers differ only in the wrap bit
   assign in_ready = !((st_reg.wp[AW] != st_reg.rp[AW]) &&
                       (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]));
   assign out_valid = st_reg.wp != st_reg.rp;
   assign out_data = st_reg.mem[st_reg.rp[AW-1:0]];
   // Push and pop
   always_comb begin
      st_next = st_reg;
      if (in_valid && in_ready) begin
         st_next.mem[st_reg.wp[AW-1:0]] = in_data;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule // rspi_fifo

// ===== rtl/rspi_link.sv
// Serial link end of the command port, clocked by the host serial clock
module rspi_link (
   input wire logic spi_sclk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic spi_sdi,
   input rspi_pkg::rspi_shadow_t shadow,
   output rspi_pkg::rspi_byte_evt_t byte_evt,
   output logic sdo_out,
   output logic sdo_oe_n
);
   typedef struct packed {
      logic [2:0] bitcnt;
      logic [6:0] nbytes;
      logic [7:0] shift;
      logic [7:0] cmd;
   } rspi_link_st_t;
   rspi_link_st_t st_reg;
   rspi_link_st_t st_next;
   logic [7:0] tx_reg;
   logic [7:0] next_byte;
   logic [7:0] in_byte;
   logic [6:0] k;
   logic frame_rst;
   // Raised select ends the frame and clears the shifter
   assign frame_rst = rst | chip_select_n;
   assign in_byte = {st_reg.shift[6:0], spi_sdi};
   assign k = st_reg.nbytes - 7'h01;
   // Input sampled on rising edges, MSB first
   always_comb begin
      st_next = st_reg;
      st_next.bitcnt = st_reg.bitcnt + 3'h1;
      st_next.shift = in_byte;
      if (st_reg.bitcnt == 3'h7) begin
         if (st_reg.nbytes != 7'h7F) begin
            st_next.nbytes = st_reg.nbytes + 7'h01;
         end
         if (st_reg.nbytes == 7'h00) begin
            st_next.cmd = in_byte;
         end
      end
   end
   always_ff @(posedge spi_sclk or posedge frame_rst) begin
      if (frame_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   // Byte event toggle survives select so the core never sees a false edge
   always_ff @(posedge spi_sclk or posedge rst) begin
      if (rst) begin
         byte_evt <= '0;
      end else if (st_reg.bitcnt == 3'h7) begin
         byte_evt.tog <= ~byte_evt.tog;
         // Only the command byte is handed over; it stands for the whole frame,
         // so the core still reads it after the slow toggle synchroniser
         if (st_reg.nbytes == 7'h00) begin
            byte_evt.data <= in_byte;
         end
      end
   end
   // Next outgoing byte after each completed byte
   always_comb begin
      next_byte = 8'h00;
      if (st_reg.cmd == rspi_pkg::CMD_QS_A || st_reg.cmd == rspi_pkg::CMD_QS_B ||
          st_reg.cmd == rspi_pkg::CMD_QS_C || st_reg.cmd == rspi_pkg::CMD_QS_D) begin
         next_byte = shadow.qs[st_reg.cmd[2:1] + k[1:0]];
      end else if (st_reg.cmd == rspi_pkg::CMD_READ_REPLY) begin
         if (k == 7'h00) begin
            next_byte = shadow.cts ? rspi_pkg::CTS_READY : rspi_pkg::CTS_BUSY;
         end else if (shadow.cts) begin
            next_byte = shadow.reply[2'(k - 7'h01)];
         end
      end else if (st_reg.cmd == rspi_pkg::CMD_READ_RX && k < shadow.rx_count) begin
         next_byte = shadow.rx_buf[shadow.rx_head + k[5:0]];
      end
   end
   // Output changes on falling edges
   always_ff @(negedge spi_sclk or posedge frame_rst) begin
      if (frame_rst) begin
         tx_reg <= 8'h00;
      end else if (st_reg.bitcnt == 3'h0 && st_reg.nbytes != 7'h00) begin
         tx_reg <= next_byte;
      end else begin
         tx_reg <= {tx_reg[6:0], 1'b0};
      end
   end
   assign sdo_out = tx_reg[7];
   assign sdo_oe_n = chip_select_n | ~shadow.link_en;
endmodule // rspi_link

// ===== testbench/rspi_port_asserts.sv
// Pin-level assertions of the command port
module rspi_port_asserts (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic chip_select_n,
   input wire logic sdo_out,
   input wire logic sdo_oe_n,
   input wire logic shutdown,
   input wire logic rx_in_ready,
   input wire logic rx_serial_bit,
   input wire logic gpio_rx_mode,
   input wire logic tx_done,
   input wire logic [7:0] pa_level,
   input wire logic tx_active,
   input wire logic rx_active,
   input wire logic gpio_rx
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int RAMP_MAX = 300;
   logic sdo_moved_hi = 1'b0;
   // Notes the clock level at each move of the data out pin
   always @(sdo_out) sdo_moved_hi = (spi_sclk === 1'b1);
   ////////////////////////////////////////////////////////////////////////////////
   // Ramp steps
   sequence s_ramp_up;
      ##[1:RAMP_MAX] (pa_level == rspi_pkg::PA_MAX);
   endsequence
   sequence s_ramp_down;
      ##[1:RAMP_MAX] (!tx_active && pa_level == 8'h00);
   endsequence
   tdd_exclusive_a: assert property (@(posedge core_clk) disable iff (rst)
      !(tx_active && rx_active)) else $error("transmit and receive overlap");
   ramp_up_a: assert property (@(posedge core_clk) disable iff (rst || shutdown)
      $rose(tx_active) |-> s_ramp_up) else $error("power ramp up missing");
   ramp_down_a: assert property (@(posedge core_clk) disable iff (rst || shutdown)
      tx_done && tx_active && pa_level == rspi_pkg::PA_MAX |-> s_ramp_down)
      else $error("power ramp down missing");
   pa_step_a: assert property (@(posedge core_clk) disable iff (rst || shutdown)
      $changed(pa_level) |-> (pa_level - $past(pa_level) == 8'h01)
      || ($past(pa_level) - pa_level == 8'h01)) else $error("power level jumped");
   pa_idle_a: assert property (@(posedge core_clk) disable iff (rst || shutdown)
      !tx_active |-> pa_level == 8'h00) else $error("power on outside transmit");
   oe_select_a: assert property (@(posedge core_clk) disable iff (rst)
      chip_select_n |-> sdo_oe_n) else $error("data out driven while deselected");
   shutdown_off_a: assert property (@(posedge core_clk) disable iff (rst)
      shutdown [*4] |-> sdo_oe_n && !tx_active && !rx_active && pa_level == 8'h00)
      else $error("activity during shutdown");
   rx_ready_a: assert property (@(posedge core_clk) disable iff (rst)
      rx_in_ready |-> rx_active) else $error("stream taken while not receiving");
   gpio_mirror_a: assert property (@(posedge core_clk) disable iff (rst || shutdown)
      gpio_rx_mode && rx_active |=> gpio_rx == $past(rx_serial_bit))
      else $error("receive pin mirror wrong");
   sdo_falling_a: assert property (@(posedge spi_sclk) disable iff (rst)
      !sdo_moved_hi) else $error("data out moved while clock high");
endmodule // rspi_port_asserts

bind rspi_port rspi_port_asserts u_chk (.core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
   .chip_select_n(chip_select_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
   .shutdown(shutdown), .rx_in_ready(rx_in_ready), .rx_serial_bit(rx_serial_bit),
   .gpio_rx_mode(gpio_rx_mode), .tx_done(tx_done), .pa_level(pa_level),
   .tx_active(tx_active), .rx_active(rx_active), .gpio_rx(gpio_rx));

// ===== testbench/rspi_host.sv
// Host model: serial master sending command frames
module rspi_host (
   output logic spi_sclk,
   output logic chip_select_n,
   output logic spi_sdi,
   input wire logic sdo_out,
   input wire logic sdo_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic miso_last = 1'b0;
   logic miso;
   // Released data line shows the inverse of its last driven level
   always @(sdo_out or sdo_oe_n) if (!sdo_oe_n) miso_last = sdo_out;
   assign miso = sdo_oe_n ? !miso_last : sdo_out;
   initial begin
      spi_sclk = 1'b0;
      chip_select_n = 1'b1;
      spi_sdi = 1'b0;
   end
   // Sends n bytes MSB first from the top of tx, clock still outside frames
   task automatic frame(input logic [63:0] tx, input int n, input int hold_ns,
         output logic [63:0] rx);
      rx = '0;
      chip_select_n = 1'b0;
      #20;
      for (int i = 0; i < n * 8; i++) begin
         spi_sdi = tx[63 - i];
         #6;
         spi_sclk = 1'b1;
         rx[63 - i] = miso;
         #6;
         spi_sclk = 1'b0;
      end
      #(20 + hold_ns);
      chip_select_n = 1'b1;
      spi_sdi = !spi_sdi;
      #300;
   endtask
endmodule // rspi_host

// ===== testbench/rspi_port_test.sv
// Self-checking bench of the command port
module rspi_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic spi_sclk, chip_select_n, spi_sdi, sdo_out, sdo_oe_n;
   logic shutdown = 1'b0;
   rspi_pkg::rspi_stream_t rx_in = '0;
   logic rx_in_ready, gpio_rx, tx_active, rx_active;
   logic rx_serial_bit = 1'b0;
   logic gpio_rx_mode = 1'b1;
   logic [3:0][1:0] qs_sel = {2'h2, 2'h3, 2'h2, 2'h0};
   logic tx_done = 1'b0;
   logic [7:0] pa_level;
   int n_fail = 0;
   int num_checks = 0;
   logic [7:0] exp_q[$];
   logic [7:0] got_q[$];
   string name_q[$];
   logic [7:0] data_q[$];
   logic [63:0] rx;
   always #25 core_clk = !core_clk;
   always @(posedge core_clk) rx_serial_bit <= 1'($urandom);
   rspi_port DUT (.core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
      .chip_select_n(chip_select_n), .spi_sdi(spi_sdi), .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n), .shutdown(shutdown), .rx_in(rx_in), .rx_in_ready(rx_in_ready),
      .rx_serial_bit(rx_serial_bit), .gpio_rx_mode(gpio_rx_mode),
      .quick_status_source_select(qs_sel), .tx_done(tx_done), .pa_level(pa_level),
      .tx_active(tx_active), .rx_active(rx_active), .gpio_rx(gpio_rx));
   rspi_host host (.spi_sclk(spi_sclk), .chip_select_n(chip_select_n), .spi_sdi(spi_sdi),
      .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (n_fail == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Notes the expectation, then hands in the seen value
   task automatic expect_val(input string what, input logic [7:0] exp, input logic [7:0] seen);
      name_q.push_back(what);
      exp_q.push_back(exp);
      got_q.push_back(seen);
   endtask
   // Takes the oldest note whenever a result arrives
   initial forever begin
      wait (got_q.size() > 0);
      check(name_q.pop_front(), got_q.pop_front(), exp_q.pop_front());
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Polls clear-to-send under a bound before any further command
   task automatic wait_cts(output int polls);
      polls = 0;
      do begin
         host.frame({rspi_pkg::CMD_READ_REPLY, 56'h0}, 6, 0, rx);
         polls++;
         if (polls > 200) begin
            n_fail++;
            test_done();
         end
      end while (rx[55:48] !== rspi_pkg::CTS_READY);
   endtask
   // Burst reads starting at each quick status code, wrapping D to A
   task automatic qs_burst(input logic [3:0][7:0] ev);
      logic [7:0] code;
      for (int k = 0; k < 4; k++) begin
         code = rspi_pkg::CMD_QS_A + 8'(2 * k);
         host.frame({code, 56'h0}, 6, 0, rx);
         for (int j = 0; j < 5; j++) begin
            expect_val("quick_status", ev[(k + j) % 4],
               rx[55 - 8 * j -: 8]);
         end
      end
   endtask
   // Offers random bytes, holding each until taken, for at most 60 cycles
   task automatic feed(input int n, output int taken);
      int tries;
      taken = 0;
      tries = 0;
      rx_in.data <= 8'($urandom);
      rx_in.valid <= 1'b1;
      while (taken < n && tries < 60) begin
         @(posedge core_clk);
         tries++;
         if (rx_in_ready === 1'b1) begin
            data_q.push_back(rx_in.data);
            taken++;
            rx_in.data <= 8'($urandom);
         end
      end
      rx_in.valid <= 1'b0;
   endtask
   task automatic read_rx(input int nb);
      host.frame({rspi_pkg::CMD_READ_RX, 56'h0}, nb, 0, rx);
      for (int j = 1; j < nb; j++) begin
         expect_val("rx_byte", (data_q.size() > 0) ? data_q.pop_front() : 8'h00,
            rx[63 - 8 * j -: 8]);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int polls, taken;
      time t0;
      void'($urandom(6714));
      cyc(12);
      rst <= 1'b0;
      cyc(4);
      // Receive start and clear-to-send delay
      host.frame({rspi_pkg::CMD_START_RX, 56'h0}, 1, 0, rx);
      t0 = $time;
      wait_cts(polls);
      expect_val("cts_delay", 8'h01, 8'(($time - t0 >= 19000) && ($time - t0 <= 23000)));
      expect_val("reply_cmd", rspi_pkg::CMD_START_RX, rx[47:40]);
      cyc(1);
      expect_val("duplex", 8'h01, {6'h00, tx_active, rx_active});
      feed(5, taken);
      cyc(20);
      qs_burst({8'h05, 8'h00, 8'h05, 8'h00});
      read_rx(7);
      // Select held low stalls draining; the FIFO fills until it refuses
      cyc(10);
      fork
         host.frame(64'h0, 0, 5000, rx);
         begin
            cyc(10);
            feed(40, taken);
         end
      join
      expect_val("fifo_fill", 8'(rspi_pkg::FIFO_DEPTH), 8'(taken));
      cyc(60);
      qs_burst({8'h20, 8'h00, 8'h20, 8'h00});
      read_rx(8);
      // Transmit with ramp, then end it
      host.frame({rspi_pkg::CMD_START_TX, 56'h0}, 1, 0, rx);
      wait_cts(polls);
      expect_val("tx_pa", rspi_pkg::PA_MAX, pa_level);
      expect_val("duplex", 8'h02, {6'h00, tx_active, rx_active});
      qs_burst({8'h19, 8'hFF, 8'h19, 8'h00});
      @(posedge core_clk);
      tx_done <= 1'b1;
      @(posedge core_clk);
      tx_done <= 1'b0;
      cyc(300);
      expect_val("pa_off", 8'h00, pa_level);
      // Shutdown ignores the link and loses the buffer
      shutdown <= 1'b1;
      cyc(10);
      fork
         host.frame({rspi_pkg::CMD_QS_B, 56'h0}, 2, 0, rx);
         begin
            #100;
            expect_val("oe_shutdown", 8'h01, {7'h00, sdo_oe_n});
         end
      join
      @(posedge core_clk);
      shutdown <= 1'b0;
      cyc(10);
      host.frame({rspi_pkg::CMD_QS_B, 56'h0}, 2, 0, rx);
      expect_val("qs_after_off", 8'h00, rx[55:48]);
      cyc(2);
      test_done();
   end
endmodule // rspi_port_test
